// [design/wdc_top.sv]
// Functional notes
// - Immediate-reset code forces system reset at once
// - Interrupt mode raises interrupt instead of reset, except with the immediate code, which still resets
// - Watchdog interrupt ignores masks and global enable
// - Interrupt mode doubles as periodic interval timer
// - Timeout always sets the timeout status flag
// - Flag cleared by zero write or hardware reset
// - Setting arm enables and clears counters
// - Control write needs unlock immediately before it
// - Select field picks period; code 7 2000 ms
`timescale 1ns/1ps
`default_nettype none
module wdc_top #(
  parameter int unsigned TICK_CYCLES = wdc_pkg::TICK_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic WDOG_RESET,
  output logic WDOG_INT,
  output logic IRQ
);
  import wdc_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus write side
  logic aw_full_q, w_full_q, bvalid_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic wr_do, wr_ctrl, wr_mask, wr_hit, rd_do, rd_stat;
  logic [3:0] wr_ofs, rd_ofs;

  assign AWREADY = !aw_full_q;
  assign WREADY = !w_full_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ofs = aw_addr_q & 4'hC;
  assign wr_ctrl = wr_do && (wr_ofs == OFS_CTRL) && w_strb_q[0];
  assign wr_mask = wr_do && (wr_ofs == OFS_MASK) && w_strb_q[0];
  assign wr_hit = (wr_ofs == OFS_CTRL) || (wr_ofs == OFS_MASK);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_do) begin
        aw_full_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end else if (wr_do) begin
        w_full_q <= 1'b0;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control register and unlock handling
  wdc_ctrl_t ctrl_q, ctrl_d, wr_val;
  wdc_state_t state_q, state_d;
  logic unlock_set, accepted, rejected, expire, tick;

  assign wr_val = wdc_ctrl_t'(w_data_q[7:0]);
  // Locked write with the unlock bit set only arms the unlock
  assign unlock_set = wr_ctrl && !ctrl_q.unlock && w_data_q[UNLOCK_BIT];
  assign accepted = wr_ctrl && ctrl_q.unlock;
  assign rejected = wr_ctrl && !ctrl_q.unlock && !w_data_q[UNLOCK_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    if (accepted) begin
      ctrl_d.tsel = wr_val.tsel;
      ctrl_d.irq_mode = wr_val.irq_mode;
      ctrl_d.arm = wr_val.arm;
      ctrl_d.tflag = ctrl_q.tflag && wr_val.tflag;
    end
    // Any next access spends the unlock, so each write needs a fresh one
    if (wr_do || rd_do) begin
      ctrl_d.unlock = 1'b0;
    end
    if (unlock_set) begin
      ctrl_d.unlock = 1'b1;
    end
    // Timeout set wins over a simultaneous software clear
    if (expire || state_q == WD_IMM) begin
      ctrl_d.tflag = 1'b1;
    end
  end

  // Of the resets only the external one clears the flag; the reset output does not loop back
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= wdc_ctrl_t'(CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Timer
  logic [31:0] pre_q;
  logic [7:0] cnt_q;
  logic refresh, running;
  logic [8:0] period;

  assign state_d = wdc_mode(ctrl_d);
  assign period = wdc_period(ctrl_q.tsel);
  assign refresh = accepted && wr_val.arm;
  assign tick = running && (pre_q == TICK_CYCLES - 1);
  assign expire = tick && ({1'b0, cnt_q} == period - 9'h001);

  always_comb begin
    running = 1'b0;
    case (state_q)
      WD_RUN: running = 1'b1;
      WD_OFF: running = 1'b0;
      WD_IMM: running = 1'b0;
      WD_RSVD: running = 1'b0;
      default: running = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= WD_OFF;
      pre_q <= 32'h0000_0000;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (refresh || !running || expire) begin
        pre_q <= 32'h0000_0000;
        cnt_q <= 8'h00;
      end else if (tick) begin
        pre_q <= 32'h0000_0000;
        cnt_q <= cnt_q + 8'h01;
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end

  // Outputs of a timeout
  logic reset_q, int_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      reset_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      // Held while the immediate code stands; the chip reset ends it
      reset_q <= (state_d == WD_IMM) || (expire && !ctrl_q.irq_mode);
      // Dedicated line, no mask or global enable can stop it
      int_q <= expire && ctrl_q.irq_mode;
    end
  end
  assign WDOG_RESET = reset_q;
  assign WDOG_INT = int_q;

  // Event status, mask and summary interrupt
  logic [1:0] stat_q, mask_q, evt;

  assign evt = {rejected, expire};
  assign IRQ = |(stat_q & mask_q);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= EVT_RESET;
      mask_q <= EVT_RESET;
    end else begin
      stat_q <= (rd_stat ? 2'b00 : stat_q) | evt;
      if (wr_mask) begin
        mask_q <= w_data_q[1:0];
      end
    end
  end

  // Bus read side
  logic rvalid_q;
  logic [31:0] rdata_q, rd_mux;
  logic [1:0] rresp_q;
  logic rd_hit;

  assign ARREADY = !rvalid_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign rd_do = ARVALID && ARREADY;
  assign rd_ofs = ARADDR & 4'hC;
  assign rd_stat = rd_do && (rd_ofs == OFS_STAT);
  assign rd_hit = 1'b1;
  assign rd_mux = (rd_ofs == OFS_CTRL) ? {24'h000000, ctrl_q} :
                  (rd_ofs == OFS_STAT) ? {30'h00000000, stat_q} :
                  (rd_ofs == OFS_MASK) ? {30'h00000000, mask_q} :
                  {24'h000000, cnt_q};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      if (rd_do) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Checks
  sequence s_unlock;
    wr_ctrl && !ctrl_q.unlock && w_data_q[UNLOCK_BIT];
  endsequence

  sequence s_locked_write;
    wr_ctrl && !ctrl_q.unlock;
  endsequence

  imm_reset_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state_q == WD_IMM |-> WDOG_RESET ##1 ctrl_q.tflag)
    else $error("immediate code without reset");

  irq_mode_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire && ctrl_q.irq_mode |=> WDOG_INT && !WDOG_RESET)
    else $error("interrupt mode gave reset");

  int_unmasked_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire && ctrl_q.irq_mode && mask_q == 2'b00 |=> WDOG_INT && stat_q[EVT_TIMEOUT])
    else $error("watchdog interrupt was masked");

  interval_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire && ctrl_q.irq_mode && !accepted |=> cnt_q == 8'h00 && pre_q == 32'h0 && state_q == WD_RUN)
    else $error("interval timer did not restart");

  flag_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire |=> ctrl_q.tflag)
    else $error("timeout flag not set");

  flag_keep_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ctrl_q.tflag && !(accepted && !wr_val.tflag) |=> ctrl_q.tflag)
    else $error("timeout flag lost");

  refresh_a: assert property (@(posedge CLK) disable iff (!rst_n)
    refresh |=> cnt_q == 8'h00 && pre_q == 32'h0)
    else $error("arm did not clear counters");

  unlock_arm_a: assert property (@(posedge CLK) disable iff (!rst_n)
    s_unlock |=> ctrl_q.unlock)
    else $error("unlock not armed");

  locked_ignore_a: assert property (@(posedge CLK) disable iff (!rst_n)
    s_locked_write |=> $stable(ctrl_q.tsel) && $stable(ctrl_q.arm) && $stable(ctrl_q.irq_mode))
    else $error("locked write took effect");

  period_2000_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire && ctrl_q.tsel == TSEL_2000MS |-> cnt_q == 8'h7F)
    else $error("2000 ms period wrong");

  reserved_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state_q == WD_RSVD && state_d == WD_RSVD |-> !expire ##1 !WDOG_INT && !WDOG_RESET)
    else $error("reserved code acted");

  unlock_once_a: assert property (@(posedge CLK) disable iff (!rst_n)
    ctrl_q.unlock && (wr_do || rd_do) |=> !ctrl_q.unlock)
    else $error("unlock reused");

  reject_flag_a: assert property (@(posedge CLK) disable iff (!rst_n)
    rejected |=> stat_q[EVT_REJECT])
    else $error("rejected write not flagged");

  unlock_only_a: assert property (@(posedge CLK) disable iff (!rst_n)
    s_unlock |=> $stable(ctrl_q.tsel) && $stable(ctrl_q.arm) && $stable(ctrl_q.irq_mode))
    else $error("unlock write changed control");

  flag_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    accepted && !wr_val.tflag && !expire && state_q != WD_IMM |=> !ctrl_q.tflag)
    else $error("zero write kept flag");

  idle_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state_q != WD_RUN |=> cnt_q == 8'h00 && pre_q == 32'h0000_0000)
    else $error("idle timer counted");

  accept_load_a: assert property (@(posedge CLK) disable iff (!rst_n)
    accepted |=> ctrl_q.tsel == $past(wr_val.tsel) && ctrl_q.arm == $past(wr_val.arm)
      && ctrl_q.irq_mode == $past(wr_val.irq_mode))
    else $error("accepted write not loaded");

  reset_mode_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire && !ctrl_q.irq_mode |=> WDOG_RESET && !WDOG_INT)
    else $error("reset mode gave interrupt");

  stat_timeout_a: assert property (@(posedge CLK) disable iff (!rst_n)
    expire |=> stat_q[EVT_TIMEOUT])
    else $error("timeout event not recorded");
endmodule : wdc_top
`default_nettype wire

// [design/wdc_pkg.sv]
package wdc_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_US = 15625;
  localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hC;

  // Control field positions
  localparam int UNLOCK_BIT = 0;
  localparam int ARM_BIT = 1;
  localparam int TFLAG_BIT = 2;
  localparam int IRQMODE_BIT = 3;
  localparam int TSEL_LSB = 4;

  // Event status bit positions
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_REJECT = 1;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // Timeout select codes
  localparam logic [3:0] TSEL_IMM = 4'h8;
  localparam logic [3:0] TSEL_2000MS = 4'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] tsel;
    logic irq_mode;
    logic tflag;
    logic arm;
    logic unlock;
  } wdc_ctrl_t;

  typedef enum logic [3:0] {
    WD_OFF = 4'b0001,
    WD_RUN = 4'b0010,
    WD_IMM = 4'b0100,
    WD_RSVD = 4'b1000
  } wdc_state_t;

  // Period in prescaler ticks: code 6 is 1000 ms, code 7 is 2000 ms
  function automatic logic [8:0] wdc_period(input logic [3:0] tsel);
    return 9'h001 << tsel[2:0];
  endfunction : wdc_period

  function automatic wdc_state_t wdc_mode(input wdc_ctrl_t c);
    if (!c.arm) begin
      return WD_OFF;
    end else if (c.tsel == TSEL_IMM) begin
      return WD_IMM;
    end else if (c.tsel > TSEL_IMM) begin
      return WD_RSVD;
    end
    return WD_RUN;
  endfunction : wdc_mode
endpackage : wdc_pkg

// [tb/wdc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module wdc_top_bench;
  import wdc_pkg::*;
  typedef struct packed {
    logic [3:0] tsel;
    logic irq;
    logic [11:0] win;
    logic [1:0] rst_n;
    logic [1:0] int_n;
    logic rst_end;
    logic flag;
  } wdc_row_t;
  logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [3:0] AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA, rd;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WDOG_RESET, WDOG_INT, IRQ, prev_r, prev_i;
  logic [1:0] BRESP, RRESP, resp;
  int error_cnt, checks_done, rst_r, int_r, br, bi;
  wdc_row_t rows [5];
  wdc_top #(.TICK_CYCLES(4)) dut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .WDOG_RESET(WDOG_RESET),
    .WDOG_INT(WDOG_INT), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Rising edges only, so the immediate level counts once
  always @(posedge CLK) begin
    rst_r <= rst_r + int'(WDOG_RESET && !prev_r);
    int_r <= int_r + int'(WDOG_INT && !prev_i);
    prev_r <= WDOG_RESET;
    prev_i <= WDOG_INT;
  end
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic hang();
    error_cnt++;
    $display("ERROR bus wait ran out");
    results();
  endtask : hang
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    if (n == 100) hang();
    resp = BRESP;
    BREADY <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a);
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    if (n == 100) hang();
    rd = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask : axi_read
  // Unlock and the control write go back to back, nothing in between
  task automatic prot(input logic [7:0] v);
    axi_write(OFS_CTRL, 32'h0000_0001);
    axi_write(OFS_CTRL, {24'h0, v});
  endtask : prot
  task automatic do_reset();
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
  endtask : do_reset
  initial begin
    RST_N = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WSTRB} = 12'h000;
    WDATA = 32'h0000_0000;
    {rst_r, int_r, prev_r, prev_i, error_cnt, checks_done} = '0;
    rows[0] = '{4'h1, 1'b0, 12'd20, 2'd2, 2'd0, 1'b0, 1'b1};
    rows[1] = '{4'h2, 1'b1, 12'd40, 2'd0, 2'd2, 1'b0, 1'b1};
    rows[2] = '{TSEL_2000MS, 1'b1, 12'd1280, 2'd0, 2'd2, 1'b0, 1'b1};
    rows[3] = '{TSEL_IMM, 1'b0, 12'd20, 2'd1, 2'd0, 1'b1, 1'b1};
    rows[4] = '{4'h9, 1'b1, 12'd40, 2'd0, 2'd0, 1'b0, 1'b0};
    do_reset();
    axi_read(OFS_CTRL);
    check("ctrl_reset", rd, {24'h0, CTRL_RESET});
    axi_read(OFS_MASK);
    check("mask_reset", rd, 32'h0);
    check("outs_reset", {WDOG_RESET, WDOG_INT, IRQ}, 3'b000);
    foreach (rows[i]) begin
      do_reset();
      prot({rows[i].tsel, rows[i].irq, 2'b01, 1'b0});
      br = rst_r;
      bi = int_r;
      repeat (rows[i].win) @(posedge CLK);
      check("rst_pulses", rst_r - br, rows[i].rst_n);
      check("int_pulses", int_r - bi, rows[i].int_n);
      check("rst_level", WDOG_RESET, rows[i].rst_end);
      check("irq_masked", IRQ, 1'b0);
      axi_read(OFS_CTRL);
      check("flag", rd[TFLAG_BIT], rows[i].flag);
    end
    do_reset();
    // Locked write is dropped and flagged
    axi_write(OFS_CTRL, 32'h0000_0012);
    axi_read(OFS_CTRL);
    check("locked_ctrl", rd, 32'h0);
    axi_read(OFS_STAT);
    check("reject_evt", rd, 32'h2);
    axi_read(OFS_STAT);
    check("stat_cleared", rd, 32'h0);
    check("rresp_okay", resp, RESP_OKAY);
    // Count word is read only, so the write is refused
    axi_write(OFS_COUNT, 32'h0000_00FF);
    check("bresp_slverr", resp, RESP_SLVERR);
    // An intervening read uses up the unlock
    axi_write(OFS_CTRL, 32'h0000_0001);
    axi_read(OFS_COUNT);
    axi_write(OFS_CTRL, 32'h0000_0012);
    axi_read(OFS_CTRL);
    check("unlock_spent", rd, 32'h0);
    // Refresh faster than the period holds off the timeout
    axi_write(OFS_MASK, 32'h0000_0001);
    check("bresp_okay", resp, RESP_OKAY);
    bi = int_r;
    repeat (5) prot(8'h2A);
    check("refreshed", int_r - bi, 0);
    repeat (20) @(posedge CLK);
    check("lapsed", int_r - bi, 1);
    check("irq_raised", IRQ, 1'b1);
    prot(8'h00);
    axi_read(OFS_CTRL);
    check("flag_zero_wr", rd, 32'h0);
    axi_read(OFS_STAT);
    check("timeout_evt", rd[EVT_TIMEOUT], 1'b1);
    @(posedge CLK);
    check("irq_cleared", IRQ, 1'b0);
    results();
  end
endmodule : wdc_top_bench
`default_nettype wire
